// *** src/tsa_pkg.sv ***
package tsa_pkg;
  // ----------------------------------------
  // sizes and encodings
  // ----------------------------------------
  localparam int TEMP_W = 9;
  localparam logic [3:0] ADDR_PREFIX = 4'h9;
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_THYST = 2'h2;
  localparam logic [1:0] PTR_TOS = 2'h3;
  localparam logic [1:0] PTR_RST = 2'h0;
  // 75.0 and 80.0 degrees in half-degree steps
  localparam logic [8:0] THYST_RST = 9'h096;
  localparam logic [8:0] TOS_RST = 9'h0a0;
  // fault queue setting 0..3 needs 1, 2, 4, 6 faults
  localparam logic [11:0] FQ_NEED = {3'h6, 3'h4, 3'h2, 3'h1};
  localparam int FQ_NEED_W = 3;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_KHZ = 25000;
  localparam int TIMEOUT_MS = 75;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
  // ----------------------------------------
  // software port map and event bits
  // ----------------------------------------
  localparam logic [3:0] SW_STATUS = 4'h0;
  localparam logic [3:0] SW_MASK = 4'h1;
  localparam logic [3:0] SW_TEMP = 4'h2;
  localparam logic [3:0] SW_CFG = 4'h3;
  localparam int EV_W = 3;
  localparam int EV_CONV = 0;
  localparam int EV_ALARM = 1;
  localparam int EV_TMO = 2;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] fault_q;
    logic pol;
    logic intr_mode;
    logic shutdown;
  } tsa_cfg_type;
  localparam tsa_cfg_type CFG_RST = 5'h00;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tsa_sw_req_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_A, ST_RX, ST_ACK_W, ST_TX, ST_RACK
  } tsa_state_type;
endpackage

// *** src/tsa_sync.sv ***
`timescale 1ns/1ps
module tsa_sync #(
  parameter int W = 5
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ----------------------------------------
  // three stages, accept once 2 and 3 agree
  // ----------------------------------------
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        s1[i] <= 1'b1;
        s2[i] <= 1'b1;
        s3[i] <= 1'b1;
        level[i] <= 1'b1;
      end
      else
      begin
        s1[i] <= pin[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i])
          level[i] <= s3[i];
      end
    end
  end
endmodule // tsa_sync

// *** src/tsa_top.sv ***
// Function
// - each conversion yields a 9-bit result; the newest is kept unless it lands in the first idle cycle after a held result, which then overwrites it
// - temperature readable at any time, giving the last completed result
// - readable value held during a bus read; newer result loaded afterwards
// - programmable delay of up to 6 over-limit conversions before alarm
// - comparator mode: alarm active when temperature rises above high limit
// - comparator mode: alarm released when temperature is below hysteresis
// - interrupt mode: alarm set above high limit, held until any bus read
// - interrupt mode: once cleared, next trip below hysteresis; alternates
// - shutdown clears the alarm output
// - power-up: comparator, active low, 80 and 75 degrees, pointer zero
// - data line low past timeout resets the interface and releases data
// - three static select pins form the low part of the bus address
// - host reads temperature, writes limits and configuration over the bus
// - values are 9-bit two's complement in D15..D7, LSB half a degree
// - pointer picks one of four registers; temperature is read only
// - two-bit fault count in D4..D3 sets consecutive faults to trip
// - D2 picks alarm polarity: zero active low, one active high
`timescale 1ns/1ps
module tsa_top
  import tsa_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = tsa_pkg::TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_bit_zero,
  input wire logic addr_select_bit_one,
  input wire logic addr_select_bit_two,
  output logic over_limit_output_out,
  output logic over_limit_output_oe,
  input wire logic conv_valid,
  input wire logic [tsa_pkg::TEMP_W-1:0] conv_result,
  input wire tsa_pkg::tsa_sw_req_type sw_req,
  output logic [7:0] sw_rdata,
  output logic irq
);
  import tsa_pkg::*;

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] TMO_LAST = CW'(TIMEOUT_CYCLES - 1);

  logic [4:0] pins;
  logic scl_f;
  logic sda_f;
  logic [2:0] sel_pins;
  logic scl_d;
  logic sda_d;
  tsa_state_type state;
  logic [3:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic rw;
  logic mack;
  logic [1:0] ptr;
  tsa_cfg_type cfg;
  logic [8:0] thyst;
  logic [8:0] tos;
  logic [8:0] temp;
  logic [8:0] pend;
  logic pend_v;
  logic os_active;
  logic want_high;
  logic [2:0] fault_cnt;
  logic [CW-1:0] low_cnt;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;

  // ----------------------------------------
  // pin sampling and bus conditions
  // ----------------------------------------
  assign pins = {scl_in, sda_in, addr_select_bit_two, addr_select_bit_one,
    addr_select_bit_zero};

  tsa_sync #(.W(5)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(pins),
    .level({scl_f, sda_f, sel_pins})
  );

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  wire scl_rise = scl_f & ~scl_d;
  wire scl_fall = ~scl_f & scl_d;
  wire start_c = scl_f & scl_d & sda_d & ~sda_f;
  wire stop_c = scl_f & scl_d & ~sda_d & sda_f;
  wire [6:0] own_addr = {ADDR_PREFIX, sel_pins};
  wire addr_hit = rx_sh[7:1] == own_addr;
  wire busy = state != ST_IDLE;

  // ----------------------------------------
  // stuck data line watchdog
  // ----------------------------------------
  // counts whoever holds the line low, our own drive included
  wire tmo_hit = ~sda_f & (low_cnt == TMO_LAST);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      low_cnt <= '0;
    else if (sda_f)
      low_cnt <= '0;
    else if (low_cnt != TMO_LAST)
      low_cnt <= low_cnt + CW'(1);
  end

  // ----------------------------------------
  // register views for the serial side
  // ----------------------------------------
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;
  always_comb
  begin
    hi_byte = temp[8:1];
    lo_byte = {temp[0], 7'h00};
    case (ptr)
      PTR_CFG:
      begin
        hi_byte = {3'h0, cfg};
        lo_byte = {3'h0, cfg};
      end
      PTR_THYST:
      begin
        hi_byte = thyst[8:1];
        lo_byte = {thyst[0], 7'h00};
      end
      PTR_TOS:
      begin
        hi_byte = tos[8:1];
        lo_byte = {tos[0], 7'h00};
      end
      default:
      begin
        hi_byte = temp[8:1];
        lo_byte = {temp[0], 7'h00};
      end
    endcase
  end
  wire [7:0] tx_byte = (byte_cnt == 2'h0) ? hi_byte : lo_byte;
  wire [1:0] byte_inc = (byte_cnt == 2'h3) ? byte_cnt : byte_cnt + 2'h1;

  // ----------------------------------------
  // serial target state machine
  // ----------------------------------------
  wire byte_in = scl_fall & (bit_cnt == 4'h8);
  wire wr_byte = (state == ST_RX) & byte_in;
  wire read_done = (state == ST_RACK) & scl_rise;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      byte_cnt <= 2'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      rw <= 1'b0;
      mack <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (tmo_hit)
    begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end
    else if (start_c)
    begin
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (stop_c)
    begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state)
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            rx_sh <= {rx_sh[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (byte_in && state == ST_RX)
          begin
            sda_oe <= 1'b1;
            state <= ST_ACK_W;
          end
          else if (byte_in && addr_hit)
          begin
            sda_oe <= 1'b1;
            rw <= rx_sh[0];
            byte_cnt <= 2'h0;
            state <= ST_ACK_A;
          end
          else if (byte_in)
            state <= ST_IDLE;
        end
        ST_ACK_A, ST_RACK:
        begin
          if (scl_rise && state == ST_RACK)
          begin
            mack <= ~sda_f;
            byte_cnt <= byte_inc;
          end
          else if (scl_fall && (state == ST_ACK_A ? rw : mack))
          begin
            tx_sh <= {tx_byte[6:0], 1'b0};
            sda_oe <= ~tx_byte[7];
            bit_cnt <= 4'h1;
            state <= ST_TX;
          end
          else if (scl_fall)
          begin
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            state <= (state == ST_ACK_A) ? ST_RX : ST_IDLE;
          end
        end
        ST_ACK_W:
        begin
          if (scl_fall)
          begin
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            byte_cnt <= byte_inc;
            state <= ST_RX;
          end
        end
        ST_TX:
        begin
          if (byte_in)
          begin
            sda_oe <= 1'b0;
            state <= ST_RACK;
          end
          else if (scl_fall)
          begin
            sda_oe <= ~tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        default:
          bit_cnt <= 4'h0;
      endcase
    end
  end
  assign sda_out = 1'b0;

  // ----------------------------------------
  // pointer, limits and configuration
  // ----------------------------------------
  // a lone first data byte fills D15..D8 and clears D7; the second byte sets D7
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr <= PTR_RST;
      cfg <= CFG_RST;
      thyst <= THYST_RST;
      tos <= TOS_RST;
    end
    else if (wr_byte && byte_cnt == 2'h0)
      ptr <= rx_sh[1:0];
    else if (wr_byte && ptr == PTR_CFG)
      cfg <= rx_sh[4:0];
    else if (wr_byte && ptr == PTR_THYST && byte_cnt == 2'h1)
      thyst <= {rx_sh, 1'b0};
    else if (wr_byte && ptr == PTR_THYST && byte_cnt == 2'h2)
      thyst[0] <= rx_sh[7];
    else if (wr_byte && ptr == PTR_TOS && byte_cnt == 2'h1)
      tos <= {rx_sh, 1'b0};
    else if (wr_byte && ptr == PTR_TOS && byte_cnt == 2'h2)
      tos[0] <= rx_sh[7];
  end

  // ----------------------------------------
  // conversion result with read freeze
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      temp <= '0;
      pend <= '0;
      pend_v <= 1'b0;
    end
    else if (conv_valid && busy)
    begin
      pend <= conv_result;
      pend_v <= 1'b1;
    end
    else if (conv_valid)
      temp <= conv_result;
    else if (pend_v && !busy)
    begin
      temp <= pend;
      pend_v <= 1'b0;
    end
  end

  // ----------------------------------------
  // alarm with fault queue
  // ----------------------------------------
  wire fault = want_high ? ($signed(conv_result) > $signed(tos))
    : ($signed(conv_result) < $signed(thyst));
  wire [2:0] need = FQ_NEED[cfg.fault_q * FQ_NEED_W +: FQ_NEED_W];
  wire [2:0] fault_inc = fault_cnt + 3'h1;
  wire trip = conv_valid & ~cfg.shutdown & fault & (fault_inc >= need);
  wire os_drive = cfg.pol ? ~os_active : os_active;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      os_active <= 1'b0;
      want_high <= 1'b1;
      fault_cnt <= 3'h0;
    end
    else if (cfg.shutdown)
    begin
      os_active <= 1'b0;
      want_high <= 1'b1;
      fault_cnt <= 3'h0;
    end
    else if (trip)
    begin
      // set beats a read landing in the same cycle
      os_active <= cfg.intr_mode | want_high;
      want_high <= ~want_high;
      fault_cnt <= 3'h0;
    end
    else
    begin
      if (conv_valid)
        fault_cnt <= fault ? fault_inc : 3'h0;
      if (read_done && cfg.intr_mode)
        os_active <= 1'b0;
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      over_limit_output_oe <= 1'b0;
    else
      over_limit_output_oe <= os_drive;
  end
  assign over_limit_output_out = 1'b0;

  // ----------------------------------------
  // software port and interrupt
  // ----------------------------------------
  wire [EV_W-1:0] ev = {tmo_hit, trip & ~os_active, conv_valid};
  wire sw_wr_st = sw_req.wr & (sw_req.addr == SW_STATUS);
  wire sw_wr_mk = sw_req.wr & (sw_req.addr == SW_MASK);
  wire [EV_W-1:0] clr = sw_wr_st ? sw_req.wdata[EV_W-1:0] : '0;
  logic [7:0] sw_sel;
  always_comb
  begin
    case (sw_req.addr)
      SW_STATUS: sw_sel = 8'({status});
      SW_MASK: sw_sel = 8'({mask});
      SW_TEMP: sw_sel = temp[8:1];
      SW_CFG: sw_sel = {os_active, pend_v, 1'b0, cfg};
      default: sw_sel = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status <= '0;
      mask <= '0;
      sw_rdata <= 8'h00;
      irq <= 1'b0;
    end
    else
    begin
      // a new event wins over a write-one clear
      status <= (status & ~clr) | ev;
      if (sw_wr_mk)
        mask <= sw_req.wdata[EV_W-1:0];
      sw_rdata <= sw_req.rd ? sw_sel : 8'h00;
      irq <= |(status & mask);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_shutdown_clear;
    cfg.shutdown |=> !os_active;
  endproperty
  a_shutdown_clear: assert property (p_shutdown_clear)
    else $error("alarm not cleared in shutdown");

  property p_read_clear;
    read_done && cfg.intr_mode && !conv_valid && !tmo_hit |=> !os_active;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("read did not clear alarm");

  property p_freeze;
    busy ##1 busy |-> $stable(temp);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("temperature changed during a transfer");

  property p_load;
    conv_valid && !busy |=> temp == $past(conv_result);
  endproperty
  a_load: assert property (p_load)
    else $error("conversion result not loaded");

  property p_foreign;
    state == ST_ADDR && byte_in && !addr_hit && !start_c && !stop_c
      |=> state == ST_IDLE && !sda_oe;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("answered a foreign address");

  property p_timeout;
    tmo_hit |=> state == ST_IDLE ##0 !sda_oe;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("interface not reset on timeout");

  property p_polarity;
    1'b1 |=> over_limit_output_oe == $past(os_drive);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("alarm pin polarity wrong");

  property p_alternate;
    trip && cfg.intr_mode |=> want_high != $past(want_high) ##0 os_active;
  endproperty
  a_alternate: assert property (p_alternate)
    else $error("interrupt trip did not alternate limits");
endmodule // tsa_top

// *** test/tsa_host.sv ***
`timescale 1ns/1ps
module tsa_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // ------------------------------
  // bus host, 320 ns bit time
  // ------------------------------
  // clock rests high between frames; data released means pulled up
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // long low phase: the target turns its data round up to 5 clocks after a fall
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    #80 sda_low = !b;
    #160 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
  endtask
  task automatic start();
    sda_low = 1'b0;
    #240 scl = 1'b1;
    #140 sda_low = 1'b1;
    #140 scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #200 scl = 1'b1;
    #160 sda_low = 1'b0;
    #160;
  endtask
  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic rx(output logic [7:0] b, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(!ack, s);
    // let go of the line once the acknowledge clock has fallen
    sda_low = 1'b0;
  endtask
endmodule // tsa_host

// *** test/tsa_top_tb.sv ***
`timescale 1ns/1ps
module tsa_top_tb;
  import tsa_pkg::*;
  localparam logic [7:0] DEV_W = {ADDR_PREFIX, 3'b101, 1'b0};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl, host_low, sda, sda_out, sda_oe, os_out, os_oe, irq;
  logic conv_valid = 1'b0;
  logic [TEMP_W-1:0] conv_result = '0;
  tsa_sw_req_type sw_req = '0;
  logic [7:0] sw_rdata;
  int n_errors = 0;
  int check_count = 0;
  // ------------------------------
  // bench plumbing
  // ------------------------------
  assign sda = !((sda_oe && !sda_out) || host_low);
  always #20 core_clk = !core_clk;
  tsa_host tsa_host_inst (.scl(scl), .sda_low(host_low), .sda(sda));
  tsa_top #(.TIMEOUT_CYCLES(200)) tsa_top_inst (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_bit_zero(1'b1), .addr_select_bit_one(1'b0),
    .addr_select_bit_two(1'b1),
    .over_limit_output_out(os_out), .over_limit_output_oe(os_oe),
    .conv_valid(conv_valid), .conv_result(conv_result),
    .sw_req(sw_req), .sw_rdata(sw_rdata), .irq(irq));
  task automatic chk(input string nm, input logic [15:0] s, e);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk) sw_req <= {a, d, 2'b10};
    @(posedge core_clk) sw_req <= '0;
  endtask
  task automatic swc(input string nm, input logic [3:0] a,
                     input logic [7:0] e);
    @(posedge core_clk) sw_req <= {a, 8'h00, 2'b01};
    @(posedge core_clk) sw_req <= '0;
    #1 chk(nm, sw_rdata, e);
  endtask
  task automatic conv(input logic [8:0] t, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      conv_valid <= 1'b1;
      conv_result <= t;
      @(posedge core_clk);
      conv_valid <= 1'b0;
      tick(4);
    end
  endtask
  task automatic wr_reg(input logic [1:0] p, input logic [7:0] b1, b2);
    logic a;
    tsa_host_inst.start();
    tsa_host_inst.tx(DEV_W, a);
    chk("write addr ack", a, 1'b1);
    tsa_host_inst.tx({6'h00, p}, a);
    tsa_host_inst.tx(b1, a);
    tsa_host_inst.tx(b2, a);
    tsa_host_inst.stop();
  endtask
  // sp low reads from the pointer left by the last access
  task automatic rd_reg(input bit sp, input logic [1:0] p,
                        output logic [15:0] v);
    logic a;
    tsa_host_inst.start();
    if (sp)
    begin
      tsa_host_inst.tx(DEV_W, a);
      tsa_host_inst.tx({6'h00, p}, a);
      tsa_host_inst.start();
    end
    tsa_host_inst.tx(DEV_W | 8'h01, a);
    chk("read addr ack", a, 1'b1);
    tsa_host_inst.rx(v[15:8], 1'b1);
    tsa_host_inst.rx(v[7:0], 1'b0);
    tsa_host_inst.stop();
  endtask
  task automatic rdc(input string nm, input logic [1:0] p,
                     input logic [15:0] e);
    logic [15:0] v;
    rd_reg(1'b1, p, v);
    chk(nm, v, e);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    logic [15:0] v;
    logic a;
    chk("alarm idle", os_oe, 1'b0);
    chk("alarm pin level", os_out, 1'b0);
    conv(9'h032, 1);
    rd_reg(1'b0, 2'h0, v);
    chk("default pointer", v, 16'h1900);
    rdc("config", 2'h1, 16'h0000);
    rdc("hyst limit", 2'h2, 16'h4b00);
    rdc("high limit", 2'h3, 16'h5000);
    tsa_host_inst.start();
    tsa_host_inst.tx(DEV_W ^ 8'h02, a);
    chk("foreign ack", a, 1'b0);
    tsa_host_inst.stop();
    swc("unmapped", 4'hf, 8'h00);
  endtask
  task automatic t_irq();
    sw_wr(SW_STATUS, 8'h07);
    sw_wr(SW_MASK, 8'h01);
    conv(9'h1ff, 1);
    chk("irq raised", irq, 1'b1);
    swc("temp port", SW_TEMP, 8'hff);
    rdc("negative temp", 2'h0, 16'hff80);
    sw_wr(SW_MASK, 8'h00);
    tick(3);
    chk("irq masked", irq, 1'b0);
    sw_wr(SW_STATUS, 8'h01);
    sw_wr(SW_MASK, 8'h01);
    tick(3);
    chk("irq cleared", irq, 1'b0);
  endtask
  task automatic t_freeze();
    logic [15:0] v;
    conv(9'h032, 1);
    fork
      rd_reg(1'b1, 2'h0, v);
      #8000 conv(9'h064, 1);
    join
    chk("frozen temp", v, 16'h1900);
    rdc("updated temp", 2'h0, 16'h3200);
    wr_reg(2'h2, 8'h28, 8'h80);
    rdc("hyst write", 2'h2, 16'h2880);
    wr_reg(2'h0, 8'h55, 8'h55);
    rdc("temp read only", 2'h0, 16'h3200);
    wr_reg(2'h2, 8'h4b, 8'h00);
  endtask
  task automatic t_comp();
    conv(9'h0a0, 1);
    chk("at high limit", os_oe, 1'b0);
    sw_wr(SW_STATUS, 8'h07);
    conv(9'h0a2, 1);
    chk("comp trip", os_oe, 1'b1);
    swc("alarm flag", SW_STATUS, 8'h03);
    conv(9'h096, 1);
    chk("comp hold", os_oe, 1'b1);
    conv(9'h094, 1);
    chk("comp release", os_oe, 1'b0);
  endtask
  task automatic t_queue();
    int need[4] = '{1, 2, 4, 6};
    logic [7:0] c;
    for (int q = 0; q < 4; q++)
    begin
      c = {3'h0, q[1:0], 3'h0};
      wr_reg(2'h1, c, c);
      conv(9'h0a2, need[q] - 1);
      chk("queue short", os_oe, 1'b0);
      conv(9'h0a2, 1);
      chk("queue trip", os_oe, 1'b1);
      conv(9'h094, need[q]);
      chk("queue clear", os_oe, 1'b0);
    end
  endtask
  task automatic t_modes();
    wr_reg(2'h1, 8'h04, 8'h04);
    chk("pol idle", os_oe, 1'b1);
    conv(9'h0a2, 1);
    chk("pol active", os_oe, 1'b0);
    conv(9'h094, 1);
    wr_reg(2'h1, 8'h02, 8'h02);
    conv(9'h0a2, 2);
    chk("intr trip", os_oe, 1'b1);
    rdc("high limit", 2'h3, 16'h5000);
    chk("intr read clear", os_oe, 1'b0);
    conv(9'h0a2, 1);
    chk("intr no retrip", os_oe, 1'b0);
    conv(9'h094, 1);
    chk("intr low trip", os_oe, 1'b1);
    wr_reg(2'h1, 8'h03, 8'h03);
    chk("shutdown clear", os_oe, 1'b0);
    conv(9'h0a2, 1);
    chk("shutdown idle", os_oe, 1'b0);
    swc("cfg port", SW_CFG, 8'h03);
    rdc("shutdown config", 2'h1, 16'h0303);
    rdc("shutdown limit", 2'h2, 16'h4b00);
    wr_reg(2'h1, 8'h00, 8'h00);
    conv(9'h0a2, 1);
  endtask
  task automatic t_tmo();
    logic [7:0] b;
    logic a;
    sw_wr(SW_STATUS, 8'h07);
    sw_wr(SW_MASK, 8'h04);
    tsa_host_inst.start();
    tsa_host_inst.tx(DEV_W | 8'h01, a);
    tsa_host_inst.rx(b, 1'b1);
    chk("short read", b, 8'h00);
    tick(10);
    chk("data held", sda_oe, 1'b1);
    tick(250);
    chk("data released", sda_oe, 1'b0);
    chk("timeout irq", irq, 1'b1);
    swc("timeout flag", SW_STATUS, 8'h04);
    sw_wr(SW_STATUS, 8'h04);
    rdc("after timeout", 2'h1, 16'h0000);
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(8);
    t_reset();
    t_irq();
    t_freeze();
    t_comp();
    t_queue();
    t_modes();
    t_tmo();
    tally_and_finish();
  end
  // hang guard
  initial
  begin
    #3000000;
    n_errors++;
    tally_and_finish();
  end
endmodule // tsa_top_tb
